// ==== cpu_regs_pkg.sv ====
package cpu_regs_pkg;
  // Register file shape
  localparam int NUM_GPR = 8;
  localparam int GPR_W = 32;
  localparam int PC_W = 24;
  localparam int SP_INDEX = 7;
  localparam logic [2:0] SP_SEL = 3'h7;

  // Address space per mode
  localparam int ADDR_W = 24;
  localparam int ADDR_W_1M = 20;
  localparam logic [23:0] NORMAL_MASK = 24'h00ffff;
  localparam logic [23:0] MB1_MASK = 24'h0fffff;
  localparam logic [23:0] ADV_MASK = 24'hffffff;

  // Flags byte fields
  localparam int FLG_IRQ_MASK = 7;
  localparam int FLG_USER_MASK = 6;
  localparam int FLG_HALF = 5;
  localparam int FLG_USER = 4;
  localparam int FLG_NEG = 3;
  localparam int FLG_ZERO = 2;
  localparam int FLG_OVF = 1;
  localparam int FLG_CARRY = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h80;

  // Half-carry tap positions
  localparam int HC_BYTE = 3;
  localparam int HC_WORD = 11;
  localparam int HC_LONG = 27;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_1MB,
    MODE_ADVANCED
  } addr_mode_t;

  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_LONG
  } op_size_t;

  // Register view select for a general register port
  typedef enum logic [2:0] {
    VIEW_LONG,
    VIEW_EXT,
    VIEW_WORD,
    VIEW_HIGH,
    VIEW_LOW
  } reg_view_t;

  // Operations that update the flags byte
  typedef enum logic [3:0] {
    FOP_NONE,
    FOP_ADD,
    FOP_ADDX,
    FOP_SUB,
    FOP_SUBX,
    FOP_CMP,
    FOP_NEG,
    FOP_LOGIC,
    FOP_SHIFT,
    FOP_BIT_ACC
  } flag_op_t;

  typedef enum logic [2:0] {
    CC_NONE,
    CC_LOAD,
    CC_AND,
    CC_OR,
    CC_XOR
  } flags_cmd_t;

  typedef enum logic [3:0] {
    BR_ALWAYS, BR_NEVER, BR_HI, BR_LS, BR_CC, BR_CS, BR_NE, BR_EQ,
    BR_VC, BR_VS, BR_PL, BR_MI, BR_GE, BR_LT, BR_GT, BR_LE
  } branch_cond_t;
endpackage

// ==== cpu_register_file_and_flags.sv ====
`timescale 1ns/100ps
// What this block does
// RULE1: One-megabyte modes keep 20 address bits; upper four bits forced to zero.
// RULE2: Normal mode spans 64 kbytes, advanced mode spans 16 Mbytes.
// RULE3: Eight interchangeable 32-bit general registers, readable as 32, 16 or 8 bits.
// RULE4: Each register splits into extended and ordinary 16-bit halves.
// RULE5: Each ordinary half splits into upper and lower byte registers.
// RULE6: Register seven is also the stack pointer for calls and exceptions.
// RULE7: Program counter is 24 bits; its lowest bit reads zero on fetch.
// RULE8: Flag bit 7 masks all but the non-maskable interrupt; exceptions set it.
// RULE9: Flag bits 6 and 4 are user bits under load, store, and, or, xor.
// RULE10: Byte arithmetic sets half-carry from carry or borrow out of bit 3.
// RULE11: Word arithmetic sets half-carry from carry or borrow at bit 11.
// RULE12: Longword arithmetic sets half-carry from carry or borrow at bit 27.
// RULE13: Negative flag takes the result's most significant bit.
// RULE14: Zero flag is set for zero result, cleared otherwise.
// RULE15: Overflow flag is set on arithmetic overflow, cleared otherwise.
// RULE16: Carry flag: add carry, subtract borrow, shifted-out bit, bit accumulator.
// RULE17: Branch conditions come from N, Z, V, C; some operations keep flags.
// RULE18: Reset loads program counter from vector, sets mask bit, nothing else; reset here clears the program counter and the other flag bits.
// RULE19: Software sets the stack pointer with a long move right after reset.
// RULE20: Odd word, longword or fetch addresses are forced even, no error.
// RULE21: Bit operations pick bit 0 to 7 of a byte; decimal adjust uses nibbles.
// RULE22: Software should access the stack only by word or longword.
// RULE23: Extended half is bits 31:16, ordinary half 15:0, upper byte 15:8.
module cpu_register_file_and_flags
  import cpu_regs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Mode
  input wire addr_mode_t addr_mode,
  // General register write port
  input wire logic gpr_we,
  input wire logic [3:0] gpr_wsel,
  input wire reg_view_t gpr_wview,
  input wire logic [31:0] gpr_wdata,
  // General register read ports
  input wire logic [3:0] gpr_rsel_a,
  input wire reg_view_t gpr_rview_a,
  output logic [31:0] gpr_rdata_a,
  input wire logic [3:0] gpr_rsel_b,
  input wire reg_view_t gpr_rview_b,
  output logic [31:0] gpr_rdata_b,
  // Stack pointer implicit access
  input wire logic sp_we,
  input wire logic [31:0] sp_wdata,
  output logic [31:0] sp_value,
  // Program counter
  input wire logic vector_load,
  input wire logic [23:0] vector_addr,
  input wire logic pc_we,
  input wire logic [23:0] pc_wdata,
  output logic [23:0] pc_value,
  output logic [23:0] fetch_addr,
  // Effective address formation
  input wire logic [31:0] ea_raw,
  input wire op_size_t ea_size,
  input wire logic ea_is_fetch,
  output logic [23:0] ea_out,
  // Flag computation from the execution unit
  input wire flag_op_t flag_op,
  input wire op_size_t flag_size,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  input wire logic [31:0] alu_result,
  input wire logic shift_out,
  input wire logic bit_acc_we,
  input wire logic bit_acc_val,
  // Flags byte commands
  input wire flags_cmd_t flags_cmd,
  input wire logic [7:0] flags_operand,
  input wire logic exception_start,
  output logic [7:0] flags_byte,
  // Bit and decimal helpers
  input wire logic [7:0] byte_operand,
  input wire logic [2:0] bit_num,
  output logic selected_bit,
  output logic [3:0] bcd_upper,
  output logic [3:0] bcd_lower,
  // Interrupt and branch
  output logic irq_masked,
  output logic user_mask_bit,
  input wire branch_cond_t branch_cond,
  output logic branch_taken
);

  logic rst_meta_ff;
  logic rst_sync_n_ff;

  // Reset enters at once but leaves on a clock edge, so no flop sees a runt
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  // General registers: left without reset, software must set them up
  logic [GPR_W-1:0] wide_gpr_ff [NUM_GPR]; // RULE3
  logic [23:0] pc_ff;
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;

  // Select code: only the low 3 bits pick the register; bit 3 is ignored, the view input picks the half
  function automatic logic [31:0] read_view(input logic [31:0] r,
                                            input reg_view_t v);
    logic [31:0] o;
    o = 32'h0;
    unique case (v)
      VIEW_LONG: o = r; // RULE3
      VIEW_EXT:  o = {16'h0, r[31:16]}; // RULE4 RULE23
      VIEW_WORD: o = {16'h0, r[15:0]}; // RULE4 RULE23
      VIEW_HIGH: o = {24'h0, r[15:8]}; // RULE5 RULE23
      VIEW_LOW:  o = {24'h0, r[7:0]}; // RULE5
      default:   o = 32'h0;
    endcase
    return o;
  endfunction

  wire logic [2:0] ridx_a = gpr_rsel_a[2:0];
  wire logic [2:0] ridx_b = gpr_rsel_b[2:0];
  wire logic [2:0] widx = gpr_wsel[2:0];

  assign gpr_rdata_a = read_view(wide_gpr_ff[ridx_a], gpr_rview_a);
  assign gpr_rdata_b = read_view(wide_gpr_ff[ridx_b], gpr_rview_b);
  assign sp_value = wide_gpr_ff[SP_INDEX]; // RULE6

  // An explicit write to register seven beats the implicit stack pointer write in one cycle
  genvar g;
  generate
    for (g = 0; g < NUM_GPR; g++) begin : gpr
      wire logic hit = gpr_we && (widx == 3'(g));
      wire logic sp_hit = sp_we && (3'(g) == SP_SEL);
      always_ff @(posedge ref_clk) begin
        if (hit) begin
          unique case (gpr_wview)
            VIEW_LONG: wide_gpr_ff[g] <= gpr_wdata; // RULE3
            VIEW_EXT:  wide_gpr_ff[g][31:16] <= gpr_wdata[15:0]; // RULE4
            VIEW_WORD: wide_gpr_ff[g][15:0] <= gpr_wdata[15:0]; // RULE4
            VIEW_HIGH: wide_gpr_ff[g][15:8] <= gpr_wdata[7:0]; // RULE5
            VIEW_LOW:  wide_gpr_ff[g][7:0] <= gpr_wdata[7:0]; // RULE5
            default:   wide_gpr_ff[g] <= wide_gpr_ff[g];
          endcase
        end else if (sp_hit) begin
          wide_gpr_ff[g] <= sp_wdata; // RULE6
        end
      end
    end
  endgenerate

  // Program counter
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      pc_ff <= 24'h000000;
    // A vector load takes priority over a plain write
    end else if (vector_load) begin
      pc_ff <= vector_addr; // RULE18
    end else if (pc_we) begin
      pc_ff <= pc_wdata;
    end
  end

  assign pc_value = pc_ff; // RULE7
  assign fetch_addr = {pc_ff[23:1], 1'b0}; // RULE7 RULE20

  // Address width per mode
  wire logic [23:0] mode_mask =
    (addr_mode == MODE_NORMAL) ? NORMAL_MASK :
    (addr_mode == MODE_1MB) ? MB1_MASK : ADV_MASK; // RULE1 RULE2
  wire logic force_even = ea_is_fetch || (ea_size != SZ_BYTE);
  wire logic [23:0] ea_masked = ea_raw[23:0] & mode_mask; // RULE1 RULE2
  assign ea_out = {ea_masked[23:1], ea_masked[0] & ~force_even}; // RULE20

  // Flag computation
  wire logic is_sub = (flag_op == FOP_SUB) || (flag_op == FOP_SUBX) ||
                      (flag_op == FOP_CMP) || (flag_op == FOP_NEG);
  wire logic is_arith = (flag_op == FOP_ADD) || (flag_op == FOP_ADDX) ||
                        is_sub;
  wire logic uses_x = (flag_op == FOP_ADDX) || (flag_op == FOP_SUBX);
  // Negate is zero minus the operand on b
  wire logic [31:0] opa = (flag_op == FOP_NEG) ? 32'h0 : alu_a;
  wire logic [31:0] opb = is_sub ? ~alu_b : alu_b;
  wire logic cin = is_sub ^ (uses_x & flags_ff[FLG_CARRY]);
  wire logic [32:0] sum_full = {1'b0, opa} + {1'b0, opb} + {32'h0, cin};
  // Carry into bit n+1 = result bit n+1 xor operand bits n+1
  wire logic [31:0] carry_in_vec = sum_full[31:0] ^ opa ^ opb;

  // Carry out of each size; subtracts invert it into a borrow
  wire logic cy_byte = carry_in_vec[8];
  wire logic cy_word = carry_in_vec[16];
  wire logic cy_long = sum_full[32];
  // Half-carry taps, borrows when subtracting
  wire logic hc_byte = carry_in_vec[HC_BYTE+1] ^ is_sub; // RULE10
  wire logic hc_word = carry_in_vec[HC_WORD+1] ^ is_sub; // RULE11
  wire logic hc_long = carry_in_vec[HC_LONG+1] ^ is_sub; // RULE12
  // Overflow is the carry into the sign bit against the carry out
  wire logic ovf_byte = carry_in_vec[7] ^ cy_byte;
  wire logic ovf_word = carry_in_vec[15] ^ cy_word;
  wire logic ovf_long = carry_in_vec[31] ^ cy_long;
  // Zero test on the bits that the operand size covers
  wire logic zero_byte = (alu_result[7:0] == 8'h0);
  wire logic zero_word = (alu_result[15:0] == 16'h0);
  wire logic zero_long = (alu_result == 32'h0);

  logic msb;
  logic cy_out;
  logic hc;
  logic ovf;
  logic res_zero;
  always_comb begin
    msb = 1'b0;
    cy_out = 1'b0;
    hc = 1'b0;
    ovf = 1'b0;
    res_zero = 1'b0;
    unique case (flag_size)
      SZ_BYTE: begin
        msb = alu_result[7];
        cy_out = cy_byte;
        hc = hc_byte; // RULE10
        ovf = ovf_byte;
        res_zero = zero_byte;
      end
      SZ_WORD: begin
        msb = alu_result[15];
        cy_out = cy_word;
        hc = hc_word; // RULE11
        ovf = ovf_word;
        res_zero = zero_word;
      end
      SZ_LONG: begin
        msb = alu_result[31];
        cy_out = cy_long;
        hc = hc_long; // RULE12
        ovf = ovf_long;
        res_zero = zero_long;
      end
      default: begin
        msb = 1'b0;
      end
    endcase
  end

  // Extend forms keep Z set only if it was already set
  wire logic z_next = uses_x ? (res_zero & flags_ff[FLG_ZERO]) : res_zero;

  always_comb begin
    nxt_flags = flags_ff; // RULE17
    if (is_arith) begin
      nxt_flags[FLG_HALF] = hc; // RULE10 RULE11 RULE12
      nxt_flags[FLG_NEG] = msb; // RULE13
      nxt_flags[FLG_ZERO] = z_next; // RULE14
      nxt_flags[FLG_OVF] = ovf; // RULE15
      nxt_flags[FLG_CARRY] = cy_out ^ is_sub; // RULE16
    end
    unique case (flag_op)
      FOP_LOGIC: begin
        nxt_flags[FLG_NEG] = msb; // RULE13
        nxt_flags[FLG_ZERO] = res_zero; // RULE14
        nxt_flags[FLG_OVF] = 1'b0; // RULE15
      end
      FOP_SHIFT: begin
        nxt_flags[FLG_NEG] = msb;
        nxt_flags[FLG_ZERO] = res_zero;
        nxt_flags[FLG_OVF] = 1'b0;
        nxt_flags[FLG_CARRY] = shift_out; // RULE16
      end
      FOP_BIT_ACC: begin
        nxt_flags[FLG_CARRY] = bit_acc_val; // RULE16 RULE21
      end
      default: begin
        nxt_flags = nxt_flags;
      end
    endcase
    if (bit_acc_we) begin
      nxt_flags[FLG_CARRY] = bit_acc_val; // RULE16
    end
    // Flag commands override this cycle's update; AND, OR and XOR work on the stored byte
    unique case (flags_cmd)
      CC_LOAD: nxt_flags = flags_operand; // RULE9
      CC_AND:  nxt_flags = flags_ff & flags_operand; // RULE9
      CC_OR:   nxt_flags = flags_ff | flags_operand; // RULE9
      CC_XOR:  nxt_flags = flags_ff ^ flags_operand; // RULE9
      default: nxt_flags = nxt_flags;
    endcase
    // Exception entry or a vector load sets the mask bit over everything else in the same cycle
    if (exception_start || vector_load) begin
      nxt_flags[FLG_IRQ_MASK] = 1'b1; // RULE8 RULE18
    end
  end

  // Reset sets the mask bit and clears the other seven flag bits to zero
  always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      flags_ff <= FLAGS_RESET; // RULE18
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_byte = flags_ff; // RULE9
  assign irq_masked = flags_ff[FLG_IRQ_MASK]; // RULE8
  assign user_mask_bit = flags_ff[FLG_USER_MASK]; // RULE9

  // Bit select and decimal digits
  assign selected_bit = byte_operand[bit_num]; // RULE21
  assign bcd_upper = byte_operand[7:4]; // RULE21
  assign bcd_lower = byte_operand[3:0]; // RULE21

  // Branch conditions
  wire logic fc = flags_ff[FLG_CARRY];
  wire logic fv = flags_ff[FLG_OVF];
  wire logic fz = flags_ff[FLG_ZERO];
  wire logic fn = flags_ff[FLG_NEG];
  always_comb begin
    branch_taken = 1'b0;
    unique case (branch_cond) // RULE17
      BR_ALWAYS: branch_taken = 1'b1;
      BR_NEVER:  branch_taken = 1'b0;
      BR_HI:     branch_taken = ~(fc | fz);
      BR_LS:     branch_taken = fc | fz;
      BR_CC:     branch_taken = ~fc;
      BR_CS:     branch_taken = fc;
      BR_NE:     branch_taken = ~fz;
      BR_EQ:     branch_taken = fz;
      BR_VC:     branch_taken = ~fv;
      BR_VS:     branch_taken = fv;
      BR_PL:     branch_taken = ~fn;
      BR_MI:     branch_taken = fn;
      BR_GE:     branch_taken = ~(fn ^ fv);
      BR_LT:     branch_taken = fn ^ fv;
      BR_GT:     branch_taken = ~(fz | (fn ^ fv));
      BR_LE:     branch_taken = fz | (fn ^ fv);
    endcase
  end

endmodule

// ==== cpu_regs_assertions.sv ====
`timescale 1ns/100ps
module cpu_regs_watch
  import cpu_regs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Address formation
  input wire addr_mode_t addr_mode,
  input wire op_size_t ea_size,
  input wire logic ea_is_fetch,
  input wire logic [23:0] ea_out,
  // Program counter
  input wire logic vector_load,
  input wire logic [23:0] vector_addr,
  input wire logic [23:0] pc_value,
  input wire logic [23:0] fetch_addr,
  // Flags
  input wire flag_op_t flag_op,
  input wire flags_cmd_t flags_cmd,
  input wire logic exception_start,
  input wire logic [7:0] flags_byte,
  input wire logic irq_masked,
  input wire logic user_mask_bit,
  // Stack pointer
  input wire logic sp_we,
  input wire logic gpr_we,
  input wire logic [31:0] sp_wdata,
  input wire logic [31:0] sp_value
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  ea_upper_a: assert property (addr_mode == MODE_1MB |->
    ea_out[23:20] == 4'h0) else $error("upper address bits kept");
  ea_normal_a: assert property (addr_mode == MODE_NORMAL |->
    ea_out[23:16] == 8'h00) else $error("normal mode above 64k");
  ea_even_a: assert property (ea_size != SZ_BYTE || ea_is_fetch |->
    !ea_out[0]) else $error("odd word address passed");
  fetch_even_a: assert property (
    fetch_addr == {pc_value[23:1], 1'h0}) else $error("fetch address wrong");
  vector_load_a: assert property (vector_load && flag_op == FOP_NONE &&
    flags_cmd == CC_NONE |=> pc_value == $past(vector_addr) && flags_byte[7])
    else $error("vector load wrong");
  exc_mask_a: assert property (exception_start && flag_op == FOP_NONE &&
    flags_cmd == CC_NONE |=> flags_byte[7]) else $error("mask not set");
  mask_outs_a: assert property (irq_masked == flags_byte[7] &&
    user_mask_bit == flags_byte[6]) else $error("mask outputs wrong");
  stack_write_a: assert property (sp_we && !gpr_we |=>
    sp_value == $past(sp_wdata)) else $error("stack pointer write lost");

  cover property (vector_load);
  cover property (exception_start);
  cover property (sp_we && !gpr_we);
endmodule

bind cpu_register_file_and_flags cpu_regs_watch cpu_regs_watch_i (.*);

// ==== cpu_register_file_and_flags_bench.sv ====
`timescale 1ns/100ps
module cpu_register_file_and_flags_bench
  import cpu_regs_pkg::*;
;
  typedef struct {int k; logic [31:0] e; logic [31:0] m;} note_t;
  note_t q[$];
  note_t nt;
  int err_total = 0, n_checks = 0;
  logic [31:0] sd = 32'h2a865915, t, d, mdl [8];
  logic [23:0] e, p;
  logic [7:0] fl = 8'h80;
  logic [2:0] r;
  reg_view_t v, v2;
  flag_op_t ops [4] = '{FOP_ADD, FOP_SUB, FOP_CMP, FOP_NEG};
  logic ref_clk = 1'h0, reset_n = 1'h0, gpr_we = 1'h0, sp_we = 1'h0;
  logic pc_we = 1'h0, vector_load = 1'h0, ea_is_fetch = 1'h0;
  logic shift_out = 1'h0, bit_acc_we = 1'h0, bit_acc_val = 1'h0;
  logic exception_start = 1'h0, selected_bit, irq_masked;
  logic user_mask_bit, branch_taken;
  logic [2:0] bit_num = 3'h0;
  logic [3:0] gpr_wsel = 4'h0, gpr_rsel_a = 4'h0, gpr_rsel_b = 4'h0;
  logic [3:0] bcd_upper, bcd_lower;
  logic [7:0] flags_operand = 8'h0, byte_operand = 8'h0, flags_byte;
  logic [23:0] vector_addr = 24'h0, pc_wdata = 24'h0;
  logic [23:0] pc_value, fetch_addr, ea_out;
  logic [31:0] gpr_wdata = 32'h0, sp_wdata = 32'h0, ea_raw = 32'h0;
  logic [31:0] alu_a = 32'h0, alu_b = 32'h0, alu_result = 32'h0;
  logic [31:0] gpr_rdata_a, gpr_rdata_b, sp_value;
  addr_mode_t addr_mode = MODE_NORMAL;
  reg_view_t gpr_wview = VIEW_LONG, gpr_rview_a = VIEW_LONG;
  reg_view_t gpr_rview_b = VIEW_LONG;
  op_size_t ea_size = SZ_BYTE, flag_size = SZ_BYTE;
  flag_op_t flag_op = FOP_NONE;
  flags_cmd_t flags_cmd = CC_NONE;
  branch_cond_t branch_cond = BR_ALWAYS;

  cpu_register_file_and_flags cpu_register_file_and_flags_i (.*);

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nxt();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction

  function automatic logic [31:0] vw(logic [31:0] x, reg_view_t w);
    case (w)
      VIEW_EXT: return {16'h0, x[31:16]};
      VIEW_WORD: return {16'h0, x[15:0]};
      VIEW_HIGH: return {24'h0, x[15:8]};
      VIEW_LOW: return {24'h0, x[7:0]};
      default: return x;
    endcase
  endfunction

  function automatic logic [31:0] up(logic [31:0] x, reg_view_t w,
                                     logic [31:0] y);
    case (w)
      VIEW_EXT: return {y[15:0], x[15:0]};
      VIEW_WORD: return {x[31:16], y[15:0]};
      VIEW_HIGH: return {x[31:16], y[7:0], x[7:0]};
      VIEW_LOW: return {x[31:8], y[7:0]};
      default: return y;
    endcase
  endfunction

  function automatic logic br(int c, logic [7:0] f);
    logic [15:0] tb;
    tb = {f[2] | (f[3] ^ f[1]), !f[2] && f[3] == f[1], f[3] ^ f[1],
          f[3] == f[1], f[3], !f[3], f[1], !f[1], f[2], !f[2], f[0],
          !f[0], f[0] | f[2], !(f[0] | f[2]), 1'h0, 1'h1};
    return tb[c];
  endfunction

  function automatic logic [31:0] obs(int k);
    case (k)
      0: return gpr_rdata_a;
      1: return gpr_rdata_b;
      2: return {24'h0, flags_byte};
      3: return {8'h0, ea_out};
      4: return {8'h0, pc_value};
      5: return sp_value;
      6: return {31'h0, branch_taken};
      7: return {8'h0, fetch_addr};
      8: return {24'h0, bcd_upper, bcd_lower};
      default: return {31'h0, selected_bit};
    endcase
  endfunction

  task automatic ex(int k, logic [31:0] x, logic [31:0] m = 32'hffffffff);
    q.push_back('{k, x, m});
  endtask

  // Outputs are settled by the falling edge, so notes are judged there
  always @(negedge ref_clk) begin
    while (q.size() > 0) begin
      nt = q.pop_front();
      n_checks++;
      if ((obs(nt.k) & nt.m) !== (nt.e & nt.m)) begin
        err_total++;
        $display("mismatch %0t kind %0d got %h", $time, nt.k, obs(nt.k));
      end
    end
  end

  task automatic fc(flags_cmd_t c, logic [7:0] x);
    @(posedge ref_clk);
    flags_cmd <= c;
    flags_operand <= x;
    @(posedge ref_clk);
    flags_cmd <= CC_NONE;
    case (c)
      CC_LOAD: fl = x;
      CC_AND: fl = fl & x;
      CC_OR: fl = fl | x;
      default: fl = fl ^ x;
    endcase
    ex(2, {24'h0, fl});
  endtask

  task automatic ar(flag_op_t o, op_size_t s, int j);
    logic [32:0] a, b, y, m;
    logic sb;
    int w;
    w = s == SZ_BYTE ? 8 : s == SZ_WORD ? 16 : 32;
    m = (33'h1 << w) - 33'h1;
    a = {1'h0, nxt()} & m;
    b = {1'h0, nxt()} & m;
    if (o == FOP_NEG) a = 33'h0;
    if (o == FOP_CMP && j == 0) b = a;
    sb = o != FOP_ADD;
    y = sb ? a - b : a + b;
    @(posedge ref_clk);
    flag_op <= o;
    flag_size <= s;
    alu_a <= a[31:0];
    alu_b <= b[31:0];
    alu_result <= y[31:0] & m[31:0];
    @(posedge ref_clk);
    flag_op <= FOP_NONE;
    fl[5] = a[w - 4] ^ b[w - 4] ^ y[w - 4];
    fl[3] = y[w - 1];
    fl[2] = (y & m) == 33'h0;
    fl[1] = (a[w - 1] ^ y[w - 1]) & ~(a[w - 1] ^ b[w - 1] ^ sb);
    fl[0] = y[w];
    ex(2, {24'h0, fl});
  endtask

  task automatic fo(flag_op_t o, logic [31:0] a, logic [31:0] y, logic bv,
                    logic [7:0] x, logic [7:0] m);
    @(posedge ref_clk);
    flag_op <= o;
    flag_size <= SZ_BYTE;
    alu_a <= a;
    alu_b <= 32'h0;
    alu_result <= y;
    bit_acc_val <= bv;
    @(posedge ref_clk);
    flag_op <= FOP_NONE;
    ex(2, {24'h0, x}, {24'h0, m});
  endtask

  task automatic results();
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    results();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    ex(2, 32'h80);
    for (int i = 0; i < 48; i++) begin
      t = nxt();
      d = nxt();
      r = i < 8 ? 3'(i) : t[2:0];
      v = i < 8 ? VIEW_LONG : reg_view_t'(t[5:3] % 5);
      v2 = reg_view_t'(t[8:6] % 5);
      @(posedge ref_clk);
      gpr_we <= 1'h1;
      gpr_wsel <= {1'h0, r};
      gpr_wview <= v;
      gpr_wdata <= d;
      @(posedge ref_clk);
      gpr_we <= 1'h0;
      mdl[r] = up(mdl[r], v, d);
      gpr_rsel_a <= {1'h0, r};
      gpr_rsel_b <= {1'h0, r};
      gpr_rview_a <= v;
      gpr_rview_b <= v2;
      ex(0, vw(mdl[r], v));
      ex(1, vw(mdl[r], v2));
    end
    d = nxt();
    @(posedge ref_clk);
    sp_we <= 1'h1;
    sp_wdata <= d;
    @(posedge ref_clk);
    sp_we <= 1'h0;
    gpr_rsel_a <= 4'h7;
    gpr_rview_a <= VIEW_LONG;
    ex(5, d);
    ex(0, d);
    @(posedge ref_clk);
    gpr_we <= 1'h1;
    gpr_wsel <= 4'h7;
    gpr_wview <= VIEW_LONG;
    gpr_wdata <= ~d;
    sp_we <= 1'h1;
    @(posedge ref_clk);
    gpr_we <= 1'h0;
    sp_we <= 1'h0;
    ex(5, ~d);
    fc(CC_LOAD, 8'h00);
    fc(CC_OR, 8'h50);
    fc(CC_XOR, 8'h10);
    fc(CC_AND, 8'hbf);
    t = nxt();
    p = {t[23:1], 1'h1};
    @(posedge ref_clk);
    vector_load <= 1'h1;
    vector_addr <= p;
    pc_we <= 1'h1;
    pc_wdata <= ~p;
    @(posedge ref_clk);
    vector_load <= 1'h0;
    pc_we <= 1'h0;
    fl[7] = 1'h1;
    ex(4, {8'h0, p});
    ex(7, {8'h0, p[23:1], 1'h0});
    ex(2, {24'h0, fl});
    @(posedge ref_clk);
    pc_we <= 1'h1;
    @(posedge ref_clk);
    pc_we <= 1'h0;
    ex(4, {8'h0, ~p});
    fc(CC_LOAD, 8'h00);
    @(posedge ref_clk);
    exception_start <= 1'h1;
    @(posedge ref_clk);
    exception_start <= 1'h0;
    ex(2, 32'h80);
    for (int c = 0; c < 16; c++) begin
      t = nxt();
      fc(CC_LOAD, t[7:0]);
      branch_cond <= branch_cond_t'(c);
      ex(6, {31'h0, br(c, fl)});
    end
    for (int i = 0; i < 36; i++) ar(ops[i % 4], op_size_t'(i / 4 % 3), i / 12);
    @(posedge ref_clk);
    flag_op <= FOP_SHIFT;
    shift_out <= 1'h1;
    alu_result <= 32'h0;
    @(posedge ref_clk);
    flag_op <= FOP_NONE;
    ex(2, 32'h05, 32'h0f);
    fo(FOP_ADDX, 32'hff, 32'h0, 1'h0, 8'h25, 8'h2f);
    fo(FOP_LOGIC, 32'h0, 32'h80, 1'h0, 8'h09, 8'h0f);
    fo(FOP_BIT_ACC, 32'h0, 32'h0, 1'h0, 8'h08, 8'h0f);
    @(posedge ref_clk);
    bit_acc_we <= 1'h1;
    bit_acc_val <= 1'h1;
    @(posedge ref_clk);
    bit_acc_we <= 1'h0;
    ex(2, 32'h1, 32'h01);
    for (int i = 0; i < 18; i++) begin
      t = nxt();
      e = t[23:0] & (i % 3 == 0 ? NORMAL_MASK : i % 3 == 1 ? MB1_MASK : ADV_MASK);
      if (i / 3 % 3 != 0 || i / 9 == 1) e[0] = 1'h0;
      @(posedge ref_clk);
      addr_mode <= addr_mode_t'(i % 3);
      ea_size <= op_size_t'(i / 3 % 3);
      ea_is_fetch <= i / 9 == 1;
      ea_raw <= t;
      byte_operand <= t[31:24];
      bit_num <= t[2:0];
      ex(3, {8'h0, e});
      ex(8, {24'h0, t[31:24]});
      ex(9, t >> (5'd24 + 5'(t[2:0])), 32'h1);
    end
    @(posedge ref_clk);
    @(posedge ref_clk);
    results();
  end
endmodule
